// ==== design/rds_cfg_pkg.sv ====
package rds_cfg_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS      = 8;
    localparam int SYR_PIN_NS  = 250;
    // Filter target; a pulse just over 250 ns spans one sampled edge more than this
    localparam int SYR_PIN_CYC = SYR_PIN_NS / CLK_NS - 1;

    // ****************************************
    // Register map and layout
    // ****************************************
    localparam logic [7:0]  CTRL_ADDR = 8'h00;
    localparam logic [7:0]  STAT_ADDR = 8'h04;
    localparam logic [15:0] CTRL_RST  = 16'h4902;
    localparam int          CTRL_W    = 16;

    typedef struct packed {
        logic       standard_select;
        logic       phase_select;
        logic       phase_lock;
        logic       crystal_select;
        logic       decision_mode_high;
        logic       decision_mode_low;
        logic [2:0] correction_limit;
        logic       unsynced_write_enable;
        logic       sync_and_buffer_reset;
        logic       acquisition_method;
        logic [3:0] sync_loss_protection_setting;
    } ctrl_t;

    // Incoming block summary from the decoder datapath
    typedef struct packed {
        logic       offset_ok;
        logic [2:0] offset_code;
        logic [2:0] err_bits;
        logic       uncorrectable;
    } blk_t;

    typedef enum logic [1:0] {
        DEC_HARD   = 2'h0,
        DEC_SOFT_A = 2'h1,
        DEC_SOFT_B = 2'h2
    } decision_t;

    localparam logic [2:0] ERR_UNCORR = 3'h6;
    localparam logic [2:0] OFFSET_E   = 3'h5;
    localparam logic [2:0] LIM_MAX    = 3'h5;
    localparam int         LOSS_CRIT  = 3;

    // ****************************************
    // Decoders
    // ****************************************
    function automatic logic [4:0] loss_blocks(input logic [2:0] code);
        case (code)
            3'h0: loss_blocks = 5'h03;
            3'h1: loss_blocks = 5'h04;
            3'h2: loss_blocks = 5'h05;
            3'h3: loss_blocks = 5'h06;
            3'h4: loss_blocks = 5'h08;
            3'h5: loss_blocks = 5'h0a;
            3'h6: loss_blocks = 5'h0c;
            default: loss_blocks = 5'h10;
        endcase
    endfunction : loss_blocks

    // Illegal limits fall back to detection only
    function automatic logic [2:0] corr_limit(input logic [2:0] code);
        corr_limit = (code > LIM_MAX) ? 3'h0 : code;
    endfunction : corr_limit
endpackage : rds_cfg_pkg

// ==== design/rds_sync_cfg.sv ====
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
module rds_sync_cfg (
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_b,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    // Sync reset pin
    input  wire logic               sync_reset_pin,
    // Decoder block stream
    input  wire logic               blk_strobe,
    input  wire rds_cfg_pkg::blk_t  blk,
    input  wire logic               traffic_subcarrier,
    // Status towards datapath and buffer
    output logic                    synced,
    output logic                    sync_reset_active,
    output logic                    ram_write,
    output logic                    backward_replay_ff,
    output logic [1:0]              backward_blocks_ff,
    output logic                    flags_valid_ff,
    output logic [2:0]              block_error_flags_ff,
    // Applied settings
    output rds_cfg_pkg::decision_t  decision_ff,
    output logic                    soft_active_ff,
    output logic [2:0]              corr_limit_ff,
    output logic                    offset_e_enable,
    output logic                    crystal_select,
    output logic                    phase_fixed,
    output logic                    phase_zero_deg
);
    // ****************************************
    // Declarations
    // ****************************************
    rds_cfg_pkg::ctrl_t ctrl_ff;
    logic               dph_wr_ff;
    logic [7:0]         dph_addr_ff;
    logic               aph;
    logic [31:0]        stat_word;
    logic [5:0]         pin_cnt_ff;
    logic               pin_rst;
    logic               ok_eff;
    logic               blk_uncorr;
    logic [1:0]         hist;
    logic [4:0]         loss_cnt;
    logic [4:0]         loss_thr;
    logic               acquire;
    logic               replay_pend_ff;
    logic               strobe_d_ff;
    logic               auto_phase_ff;
    logic [2:0]         lim;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign aph       = hsel && htrans[1] && hready;
    assign lim       = rds_cfg_pkg::corr_limit(ctrl_ff.correction_limit);
    assign loss_thr  = rds_cfg_pkg::loss_blocks(ctrl_ff.sync_loss_protection_setting[2:0]);

    // ****************************************
    // Bus slave
    // ****************************************
    // Zero wait states; unmapped reads give zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dph_wr_ff   <= 1'b0;
            dph_addr_ff <= 8'h00;
        end else begin
            dph_wr_ff   <= aph && hwrite;
            dph_addr_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hrdata <= 32'h0000_0000;
        end else if (aph && !hwrite) begin
            case (haddr[7:0])
                rds_cfg_pkg::CTRL_ADDR: hrdata <= {16'h0000, ctrl_ff};
                rds_cfg_pkg::STAT_ADDR: hrdata <= stat_word;
                default:                hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign stat_word = {22'h000000, loss_cnt, phase_zero_deg, replay_pend_ff,
                        sync_reset_active, pin_rst, synced};

    // Settings register; reserved bits are never stored
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_ff <= rds_cfg_pkg::CTRL_RST;
        end else if (dph_wr_ff && dph_addr_ff == rds_cfg_pkg::CTRL_ADDR) begin
            ctrl_ff <= hwdata[rds_cfg_pkg::CTRL_W-1:0];
        end
    end

    // ****************************************
    // Sync reset pin
    // ****************************************
    // Short glitches are filtered; a held pin acts like the bit
    always_ff @(posedge clock) begin
        if (!rst_b || !sync_reset_pin) begin
            pin_cnt_ff <= 6'h00;
        end else if (pin_cnt_ff != 6'(rds_cfg_pkg::SYR_PIN_CYC)) begin
            pin_cnt_ff <= pin_cnt_ff + 6'h01;
        end
    end

    assign pin_rst = sync_reset_pin && pin_cnt_ff == 6'(rds_cfg_pkg::SYR_PIN_CYC);
    assign sync_reset_active = ctrl_ff.sync_and_buffer_reset || pin_rst;

    // ****************************************
    // Offset screening and sync tracking
    // ****************************************
    assign offset_e_enable = ctrl_ff.standard_select;
    assign ok_eff = blk.offset_ok &&
                    (offset_e_enable || blk.offset_code != rds_cfg_pkg::OFFSET_E);

    sync_tracker u_trk (
        .clock       (clock),
        .rst_b       (rst_b),
        .clear       (sync_reset_active),
        .acq_method  (ctrl_ff.acquisition_method),
        .loss_crit   (ctrl_ff.sync_loss_protection_setting[rds_cfg_pkg::LOSS_CRIT]),
        .loss_thr    (loss_thr),
        .strobe      (blk_strobe),
        .ok          (ok_eff),
        .uncorr      (blk_uncorr),
        .synced_ff   (synced),
        .hist_ff     (hist),
        .loss_cnt_ff (loss_cnt),
        .acquire     (acquire)
    );
    assign blk_uncorr = blk.uncorrectable || blk.err_bits > lim;

    // ****************************************
    // Buffer write and backward replay
    // ****************************************
    // A pending replay is armed while reset holds, spent on acquisition
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            replay_pend_ff     <= 1'b0;
            backward_replay_ff <= 1'b0;
            backward_blocks_ff <= 2'h0;
        end else begin
            backward_replay_ff <= acquire && replay_pend_ff;
            if (sync_reset_active) begin
                replay_pend_ff <= 1'b1;
            end else if (acquire) begin
                replay_pend_ff <= 1'b0;
            end
            if (acquire) begin
                backward_blocks_ff <= ctrl_ff.acquisition_method ? 2'h1 : 2'h2;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            strobe_d_ff <= 1'b0;
        end else begin
            strobe_d_ff <= blk_strobe && !sync_reset_active;
        end
    end

    // Judged on sync state after the block was counted
    assign ram_write = strobe_d_ff && !sync_reset_active &&
                       (synced || ctrl_ff.unsynced_write_enable);

    // ****************************************
    // Error flags and decision mode
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flags_valid_ff       <= 1'b0;
            block_error_flags_ff <= 3'h0;
        end else begin
            flags_valid_ff <= blk_strobe;
            if (blk_strobe) begin
                if (blk_uncorr) begin
                    block_error_flags_ff <= rds_cfg_pkg::ERR_UNCORR;
                end else begin
                    block_error_flags_ff <= blk.err_bits;
                end
            end
        end
    end

    // Illegal decision code falls back to hard decision
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            decision_ff    <= rds_cfg_pkg::DEC_SOFT_B;
            soft_active_ff <= 1'b1;
            corr_limit_ff  <= 3'h0;
        end else begin
            corr_limit_ff <= lim;
            case ({ctrl_ff.decision_mode_high, ctrl_ff.decision_mode_low})
                2'h1: decision_ff <= rds_cfg_pkg::DEC_SOFT_A;
                2'h2: decision_ff <= rds_cfg_pkg::DEC_SOFT_B;
                default: decision_ff <= rds_cfg_pkg::DEC_HARD;
            endcase
            soft_active_ff <= ctrl_ff.decision_mode_high ^ ctrl_ff.decision_mode_low;
        end
    end

    // ****************************************
    // Crystal and demodulation phase
    // ****************************************
    assign crystal_select = ctrl_ff.crystal_select;
    assign phase_fixed    = ctrl_ff.phase_lock;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            auto_phase_ff <= 1'b1;
        end else if (sync_reset_active) begin
            auto_phase_ff <= ctrl_ff.phase_select;
        end else begin
            auto_phase_ff <= traffic_subcarrier;
        end
    end

    // Host should lock the phase when subcarrier presence is known
    assign phase_zero_deg = ctrl_ff.phase_lock ? ctrl_ff.phase_select : auto_phase_ff;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence good_blk;
        blk_strobe && ok_eff && !sync_reset_active;
    endsequence

    sequence hunt_two_consec;
        (!synced && ctrl_ff.acquisition_method && hist[0]) and good_blk;
    endsequence

    sequence hunt_two_of_three;
        (!synced && !ctrl_ff.acquisition_method && hist == 2'h2) and good_blk;
    endsequence

    // Release edge; tracker must come out of reset empty
    sequence reset_release;
        sync_reset_active ##1 !sync_reset_active;
    endsequence

    sequence unsynced_blk;
        blk_strobe && !sync_reset_active && ctrl_ff.unsynced_write_enable;
    endsequence

    acq_consec_a: assert property (hunt_two_consec |=> synced)
        else $error("consecutive acquisition missed");
    acq_two_three_a: assert property (hunt_two_of_three |=> synced)
        else $error("two of three acquisition missed");
    acq_strict_a: assert property (!synced && ctrl_ff.acquisition_method && !hist[0] |=> !synced)
        else $error("acquired without consecutive blocks");
    loss_offset_a: assert property (synced && blk_strobe && !ok_eff && !sync_reset_active &&
                                    !ctrl_ff.sync_loss_protection_setting[3] && loss_cnt == loss_thr - 5'h01
                                    |=> !synced)
        else $error("offset loss not declared");
    loss_uncorr_a: assert property (synced && blk_strobe && blk_uncorr && !sync_reset_active &&
                                    ctrl_ff.sync_loss_protection_setting[3] && loss_cnt == loss_thr - 5'h01
                                    |=> !synced)
        else $error("uncorrectable loss not declared");
    loss_below_a: assert property (synced |-> loss_cnt < loss_thr)
        else $error("loss count passed threshold");
    loss_restart_a: assert property (synced && blk_strobe && ok_eff && !sync_reset_active &&
                                     !ctrl_ff.sync_loss_protection_setting[3] |=> loss_cnt == 5'h00)
        else $error("loss count not restarted");
    reset_vals_a: assert property (@(posedge clock) disable iff (1'b0)
                                   !rst_b |=> ctrl_ff == rds_cfg_pkg::CTRL_RST && decision_ff == rds_cfg_pkg::DEC_SOFT_B)
        else $error("settings reset value wrong");
    hold_reset_a: assert property (sync_reset_active |=> !synced && hist == 2'h0)
        else $error("sync held during reset");
    capture_start_a: assert property (reset_release |-> !synced && hist == 2'h0)
        else $error("capture not restarted at release");
    ram_gate_a: assert property (ram_write |-> $past(blk_strobe) && !sync_reset_active &&
                                 (synced || ctrl_ff.unsynced_write_enable))
        else $error("buffer write not allowed");
    ram_synced_a: assert property (blk_strobe && !sync_reset_active |=>
                                   sync_reset_active || !synced || ram_write)
        else $error("synced block not written");
    ram_unsynced_a: assert property (unsynced_blk ##1 !sync_reset_active && ctrl_ff.unsynced_write_enable
                                     |-> ram_write)
        else $error("unsynced block not written");
    replay_pulse_a: assert property (acquire && replay_pend_ff |=>
                                     backward_replay_ff ##1 !backward_replay_ff)
        else $error("backward replay not signalled");
    err_over_a: assert property (blk_strobe && blk.err_bits > lim |=>
                                 block_error_flags_ff == rds_cfg_pkg::ERR_UNCORR)
        else $error("excess errors not flagged");
    err_pass_a: assert property (blk_strobe && !blk_uncorr |=>
                                 block_error_flags_ff == $past(blk.err_bits))
        else $error("correctable count not passed on");
    limit_legal_a: assert property (ctrl_ff.correction_limit > rds_cfg_pkg::LIM_MAX |=>
                                    corr_limit_ff == 3'h0)
        else $error("illegal correction limit used");
    pin_filter_a: assert property (sync_reset_pin [*8] ##0 pin_cnt_ff < 6'h08 &&
                                   !ctrl_ff.sync_and_buffer_reset |-> !sync_reset_active)
        else $error("pin glitch caused reset");
    phase_lock_a: assert property (ctrl_ff.phase_lock |-> phase_zero_deg == ctrl_ff.phase_select)
        else $error("locked phase wrong");
    phase_start_a: assert property (sync_reset_active |=> auto_phase_ff == $past(ctrl_ff.phase_select))
        else $error("start phase not taken from select");
    soft_a_sel_a: assert property (!ctrl_ff.decision_mode_high && ctrl_ff.decision_mode_low |=>
                                   decision_ff == rds_cfg_pkg::DEC_SOFT_A)
        else $error("soft decision A not applied");
    soft_b_sel_a: assert property (ctrl_ff.decision_mode_high && !ctrl_ff.decision_mode_low |=>
                                   decision_ff == rds_cfg_pkg::DEC_SOFT_B)
        else $error("soft decision B not applied");
    soft_run_a: assert property (ctrl_ff.decision_mode_high != ctrl_ff.decision_mode_low |=>
                                 soft_active_ff)
        else $error("soft control not running");
    e_off_a: assert property (!offset_e_enable && blk.offset_code == rds_cfg_pkg::OFFSET_E |-> !ok_eff)
        else $error("offset E accepted in RDS mode");
endmodule : rds_sync_cfg

// ==== design/sync_tracker.sv ====
`timescale 1ns/10ps
module sync_tracker (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Control
    input  wire logic       clear,
    input  wire logic       acq_method,
    input  wire logic       loss_crit,
    input  wire logic [4:0] loss_thr,
    // Block stream
    input  wire logic       strobe,
    input  wire logic       ok,
    input  wire logic       uncorr,
    // State
    output logic            synced_ff,
    output logic [1:0]      hist_ff,
    output logic [4:0]      loss_cnt_ff,
    output logic            acquire
);
    typedef enum logic {HUNT, LOCKED} trk_t;
    trk_t       state_ff;
    logic       miss;
    logic [4:0] nxt_cnt;

    assign miss    = loss_crit ? uncorr : !ok;
    assign nxt_cnt = loss_cnt_ff + 5'h01;
    assign acquire = strobe && !clear && state_ff == HUNT && ok &&
                     (acq_method ? hist_ff[0] : |hist_ff);
    assign synced_ff = (state_ff == LOCKED);

    // ****************************************
    // Offset history
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_b || clear) begin
            hist_ff <= 2'h0;
        end else if (strobe) begin
            hist_ff <= {hist_ff[0], ok};
        end
    end

    // ****************************************
    // Acquire and lose
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_b || clear) begin
            state_ff    <= HUNT;
            loss_cnt_ff <= 5'h00;
        end else begin
            case (state_ff)
                HUNT: begin
                    loss_cnt_ff <= 5'h00;
                    if (acquire) begin
                        state_ff <= LOCKED;
                    end
                end
                LOCKED: begin
                    if (strobe && miss) begin
                        if (nxt_cnt >= loss_thr) begin
                            state_ff    <= HUNT;
                            loss_cnt_ff <= 5'h00;
                        end else begin
                            loss_cnt_ff <= nxt_cnt;
                        end
                    end else if (strobe) begin
                        loss_cnt_ff <= 5'h00;
                    end
                end
                default: state_ff <= HUNT;
            endcase
        end
    end
endmodule : sync_tracker

// ==== tb/blk_source.sv ====
`timescale 1ns/10ps
module blk_source (
    // Clock
    input  wire logic         clock,
    // Block stream
    output logic              blk_strobe,
    output rds_cfg_pkg::blk_t blk
);
    initial begin
        blk_strobe = 1'b0;
        blk        = '0;
    end

    // One block per call; fields inverted between blocks so stale values never pass as valid
    task automatic send(input logic ok, input logic [2:0] err, input logic unc, input logic [2:0] code = 3'h0);
        @(posedge clock);
        blk_strobe <= 1'b1;
        blk        <= '{ok, code, err, unc};
        @(posedge clock);
        blk_strobe <= 1'b0;
        blk        <= ~blk;
        #1;
    endtask : send
endmodule : blk_source

// ==== tb/rds_sync_cfg_tb.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module rds_sync_cfg_tb;
    logic                   clock = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic                   hready, hreadyout, hresp, blk_strobe, synced, sync_reset_active;
    logic                   sync_reset_pin = 1'b0, traffic_subcarrier = 1'b0;
    logic                   ram_write, backward_replay_ff, flags_valid_ff, soft_active_ff;
    logic                   offset_e_enable, crystal_select, phase_fixed, phase_zero_deg;
    logic [1:0]             htrans = 2'h0, backward_blocks_ff;
    logic [2:0]             hsize = 3'h2, block_error_flags_ff, corr_limit_ff;
    logic [31:0]            haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    rds_cfg_pkg::blk_t      blk;
    rds_cfg_pkg::decision_t decision_ff;
    rds_cfg_pkg::ctrl_t     c;
    int                     num_errors = 0, tests_run = 0;
    int                     loss_n[8] = '{3, 4, 5, 6, 8, 10, 12, 16};
    rds_cfg_pkg::decision_t dec_exp[4] = '{rds_cfg_pkg::DEC_HARD, rds_cfg_pkg::DEC_SOFT_A,
                                           rds_cfg_pkg::DEC_SOFT_B, rds_cfg_pkg::DEC_HARD};

    assign hready = hreadyout;
    always #4 clock = ~clock;

    rds_sync_cfg dut (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .sync_reset_pin, .blk_strobe, .blk, .traffic_subcarrier,
        .synced, .sync_reset_active, .ram_write, .backward_replay_ff, .backward_blocks_ff,
        .flags_valid_ff, .block_error_flags_ff, .decision_ff, .soft_active_ff, .corr_limit_ff,
        .offset_e_enable, .crystal_select, .phase_fixed, .phase_zero_deg);
    blk_source src (.clock, .blk_strobe, .blk);

    // ****************************************
    // Bus and stimulus helpers
    // ****************************************
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        rdat = hrdata;
    endtask : xfer

    task automatic setc();
        xfer(1'b1, rds_cfg_pkg::CTRL_ADDR, {16'h0, c});
        repeat (2) @(posedge clock);
        #1;
    endtask : setc

    task automatic srst();
        c.sync_and_buffer_reset = 1'b1;
        setc();
        `CHK(sync_reset_active, 1'b1)
        `CHK(synced, 1'b0)
        c.sync_and_buffer_reset = 1'b0;
        setc();
    endtask : srst

    task automatic good(input int n);
        repeat (n) src.send(1'b1, 3'h0, 1'b0);
    endtask : good

    task automatic miss(input int n);
        repeat (n) src.send(1'b0, 3'h0, 1'b0);
    endtask : miss

    task automatic test_done();
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        test_done();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        xfer(1'b0, rds_cfg_pkg::CTRL_ADDR, 32'h0);
        `CHK(rdat, 32'h0000_4902)
        `CHK(decision_ff, rds_cfg_pkg::DEC_SOFT_B)
        `CHK(corr_limit_ff, 3'h2)
        xfer(1'b0, 8'h08, 32'h0);
        `CHK(rdat, 32'h0)
        `CHK({hreadyout, hresp}, 2'h2)
        c = rds_cfg_pkg::CTRL_RST;
        c.acquisition_method = 1'b1;
        setc();
        srst();
        repeat (2) src.send(1'b1, 3'h0, 1'b0, rds_cfg_pkg::OFFSET_E);
        `CHK(synced, 1'b0)
        good(1);
        miss(1);
        good(1);
        `CHK(synced, 1'b0)
        good(1);
        `CHK(synced, 1'b1)
        `CHK(backward_blocks_ff, 2'h1)
        `CHK(backward_replay_ff, 1'b1)
        c.acquisition_method = 1'b0;
        setc();
        srst();
        good(1);
        miss(1);
        good(1);
        `CHK(synced, 1'b1)
        `CHK(backward_blocks_ff, 2'h2)
        for (int k = 0; k < 8; k++) begin
            c.sync_loss_protection_setting = {1'b0, k[2:0]};
            setc();
            srst();
            good(2);
            miss(loss_n[k] - 1);
            good(1);
            miss(loss_n[k] - 1);
            `CHK(synced, 1'b1)
            miss(1);
            `CHK(synced, 1'b0)
        end
        // Criterion on uncorrectable blocks, threshold of three
        c.sync_loss_protection_setting = 4'h8;
        setc();
        srst();
        good(2);
        miss(5);
        `CHK(synced, 1'b1)
        src.send(1'b1, 3'h2, 1'b0);
        `CHK(block_error_flags_ff, 3'h2)
        `CHK(flags_valid_ff, 1'b1)
        src.send(1'b1, 3'h3, 1'b0);
        `CHK(block_error_flags_ff, 3'h6)
        src.send(1'b1, 3'h0, 1'b1);
        `CHK(synced, 1'b1)
        src.send(1'b1, 3'h1, 1'b1);
        `CHK(synced, 1'b0)
        c.sync_loss_protection_setting = 4'h2;
        setc();
        srst();
        miss(1);
        `CHK(ram_write, 1'b0)
        c.unsynced_write_enable = 1'b1;
        setc();
        miss(1);
        `CHK(ram_write, 1'b1)
        c.sync_and_buffer_reset = 1'b1;
        setc();
        good(2);
        `CHK(ram_write, 1'b0)
        `CHK(synced, 1'b0)
        c.sync_and_buffer_reset = 1'b0;
        c.unsynced_write_enable = 1'b0;
        setc();
        for (int i = 0; i < 8; i++) begin
            c.correction_limit = i[2:0];
            setc();
            `CHK(corr_limit_ff, (i > 5) ? 3'h0 : i[2:0])
        end
        c.correction_limit = 3'h0;
        for (int d = 0; d < 4; d++) begin
            {c.decision_mode_high, c.decision_mode_low} = d[1:0];
            setc();
            `CHK(decision_ff, dec_exp[d])
            `CHK(soft_active_ff, d == 1 || d == 2)
        end
        c.crystal_select = 1'b1;
        c.phase_lock = 1'b1;
        c.phase_select = 1'b0;
        c.standard_select = 1'b1;
        setc();
        `CHK({crystal_select, phase_fixed, phase_zero_deg, offset_e_enable}, 4'hd)
        c.phase_select = 1'b1;
        setc();
        `CHK(phase_zero_deg, 1'b1)
        c.phase_lock = 1'b0;
        setc();
        for (int t = 1; t >= 0; t--) begin
            @(posedge clock);
            traffic_subcarrier <= t[0];
            repeat (2) @(posedge clock);
            #1;
            `CHK(phase_zero_deg, t[0])
        end
        repeat (2) src.send(1'b1, 3'h0, 1'b0, rds_cfg_pkg::OFFSET_E);
        `CHK(synced, 1'b1)
        @(posedge clock);
        sync_reset_pin <= 1'b1;
        repeat (32) @(posedge clock);
        #1;
        `CHK(sync_reset_active, 1'b1)
        `CHK(synced, 1'b0)
        @(posedge clock);
        sync_reset_pin <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        `CHK(sync_reset_active, 1'b0)
        test_done();
    end
endmodule : rds_sync_cfg_tb
